//--- logic/icr_pkg.sv
// Constants, register map and field layout of the interrupt condition router.
// Assumes a 32-bit AXI4-Lite register bus and sixteen-bit condition vectors per source group.
//
// Summary of operation
// - Each condition steers independently to any destination via its own routing field.
// - Field codes 0000b to 0111b select destination output 0 to 7.
// - Code 1111b disables the condition; other codes reserved, software avoids them.
// - Every routing field resets to 0000b, destination 0.
// - Doorbell status bit n routes by field n of the same group.
// - Low register holds fields 0-7, high 8-15; field at bit 4*(n mod 8).
// - Doorbell groups 1 to 3 have identical register pairs at own offsets.
// - Receive queue n routes by field n of receive register pair.
// - Transmit queue n routes by field n of transmit register pair.
package icr_pkg;

    localparam int          ICR_NUM_GROUPS   = 6;
    localparam int          ICR_NUM_COND     = 16;
    localparam int          ICR_NUM_DEST     = 8;
    localparam int          ICR_FIELD_W      = 4;
    localparam int          ICR_FIELDS_REG   = 8;
    localparam int          ICR_ADDR_W       = 12;
    localparam int          ICR_NUM_REGS     = 2 * ICR_NUM_GROUPS;

    localparam logic [3:0]  ICR_CODE_DEST0   = 4'h0;
    localparam logic [3:0]  ICR_CODE_DEST7   = 4'h7;
    localparam logic [3:0]  ICR_CODE_DISABLE = 4'hf;
    localparam logic [31:0] ICR_ROUTE_RESET  = 32'h0000_0000;

    // Group order: doorbell 0..3, receive queues, transmit queues
    localparam logic [11:0] ICR_DB0_LOW      = 12'h280;
    localparam logic [11:0] ICR_DB0_HIGH     = 12'h284;
    localparam logic [11:0] ICR_DB1_LOW      = 12'h290;
    localparam logic [11:0] ICR_DB1_HIGH     = 12'h294;
    localparam logic [11:0] ICR_DB2_LOW      = 12'h2a0;
    localparam logic [11:0] ICR_DB2_HIGH     = 12'h2a4;
    localparam logic [11:0] ICR_DB3_LOW      = 12'h2b0;
    localparam logic [11:0] ICR_DB3_HIGH     = 12'h2b4;
    localparam logic [11:0] ICR_RXQ_LOW      = 12'h2c0;
    localparam logic [11:0] ICR_RXQ_HIGH     = 12'h2c4;
    localparam logic [11:0] ICR_TXQ_LOW      = 12'h2d0;
    localparam logic [11:0] ICR_TXQ_HIGH     = 12'h2d4;

    localparam logic [1:0]  ICR_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  ICR_RESP_SLVERR  = 2'h2;

    localparam logic [ICR_NUM_REGS*12-1:0] ICR_REG_ADDRS = {
        ICR_TXQ_HIGH, ICR_TXQ_LOW, ICR_RXQ_HIGH, ICR_RXQ_LOW,
        ICR_DB3_HIGH, ICR_DB3_LOW, ICR_DB2_HIGH, ICR_DB2_LOW,
        ICR_DB1_HIGH, ICR_DB1_LOW, ICR_DB0_HIGH, ICR_DB0_LOW};

endpackage : icr_pkg

//--- logic/icr_group_router.sv
// One source group: sixteen pending bits steered by sixteen routing fields.
// Assumes the pending vector is a level held by the status logic outside.
`timescale 1ns/1ps
module icr_group_router
    import icr_pkg::*;
(
    input  wire logic [ICR_NUM_COND-1:0]             pending,
    input  wire logic [ICR_NUM_COND*ICR_FIELD_W-1:0] fields,
    output logic      [ICR_NUM_DEST-1:0]             dest
);

    always_comb begin
        logic [ICR_FIELD_W-1:0] code;
        dest = '0;
        code = '0;
        for (int n = 0; n < ICR_NUM_COND; n++) begin
            code = fields[n*ICR_FIELD_W +: ICR_FIELD_W];
            // Codes above seven, 1111b included, reach no output
            if (pending[n] && code <= ICR_CODE_DEST7) begin
                dest[code[2:0]] = 1'b1;
            end
        end
    end

endmodule // icr_group_router

//--- logic/icr_router.sv
// Top of the interrupt condition router: AXI4-Lite routing registers and
// six group routers whose outputs are ORed onto eight destination lines.
// Assumes condition pending levels come from status registers kept elsewhere.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module icr_router
    import icr_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [ICR_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic      [1:0]              s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [ICR_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic      [31:0]             s_axi_rdata,
    output logic      [1:0]              s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic [ICR_NUM_COND-1:0] db0_pending,
    input  wire logic [ICR_NUM_COND-1:0] db1_pending,
    input  wire logic [ICR_NUM_COND-1:0] db2_pending,
    input  wire logic [ICR_NUM_COND-1:0] db3_pending,
    input  wire logic [ICR_NUM_COND-1:0] rxq_pending,
    input  wire logic [ICR_NUM_COND-1:0] txq_pending,
    output logic      [ICR_NUM_DEST-1:0] irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [31:0]                     route_reg [ICR_NUM_REGS];
    logic [ICR_NUM_COND-1:0]         pend_grp  [ICR_NUM_GROUPS];
    logic [ICR_NUM_DEST-1:0]         dest_grp  [ICR_NUM_GROUPS];

    logic                            aw_held;
    logic [ICR_ADDR_W-1:0]           aw_addr;
    logic                            w_held;
    logic [31:0]                     w_data;
    logic [3:0]                      w_strb;
    logic                            wr_go;
    logic [ICR_NUM_REGS-1:0]         wr_hit;
    logic [ICR_NUM_REGS-1:0]         rd_hit;

    function automatic logic [ICR_NUM_REGS-1:0] icr_decode(input logic [ICR_ADDR_W-1:0] a);
        logic [ICR_NUM_REGS-1:0] hit;
        hit = '0;
        for (int i = 0; i < ICR_NUM_REGS; i++) begin
            // Low two address bits ignored: accesses are word aligned
            hit[i] = (a[ICR_ADDR_W-1:2] == ICR_REG_ADDRS[i*12+2 +: 10]);
        end
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data may arrive in either order

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_go         = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit        = icr_decode(aw_addr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ICR_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (|wr_hit) ? ICR_RESP_OKAY : ICR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routing registers, byte-lane writes

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < ICR_NUM_REGS; i++) begin
                route_reg[i] <= ICR_ROUTE_RESET;
            end
        end else if (wr_go) begin
            for (int i = 0; i < ICR_NUM_REGS; i++) begin
                for (int b = 0; b < 4; b++) begin
                    if (wr_hit[i] && w_strb[b]) begin
                        route_reg[i][b*8 +: 8] <= w_data[b*8 +: 8];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_hit        = icr_decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= ICR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= ICR_RESP_SLVERR;
            for (int i = 0; i < ICR_NUM_REGS; i++) begin
                if (rd_hit[i]) begin
                    s_axi_rdata <= route_reg[i];
                    s_axi_rresp <= ICR_RESP_OKAY;
                end
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routing: each group pairs a low and high register into sixteen fields

    assign pend_grp[0] = db0_pending;
    assign pend_grp[1] = db1_pending;
    assign pend_grp[2] = db2_pending;
    assign pend_grp[3] = db3_pending;
    assign pend_grp[4] = rxq_pending;
    assign pend_grp[5] = txq_pending;

    for (genvar g = 0; g < ICR_NUM_GROUPS; g++) begin : g_group
        icr_group_router u_route (
            .pending (pend_grp[g]),
            .fields  ({route_reg[2*g+1], route_reg[2*g]}),
            .dest    (dest_grp[g])
        );
    end

    // Combinational OR so a pending level reaches the core without added latency
    always_comb begin
        irq_out = '0;
        for (int g = 0; g < ICR_NUM_GROUPS; g++) begin
            irq_out = irq_out | dest_grp[g];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_wr_done;
        wr_go ##1 s_axi_bvalid;
    endsequence

    a_reset_routes: assert property (@(posedge aclk)
        !aresetn |=> route_reg[0] == ICR_ROUTE_RESET && route_reg[11] == ICR_ROUTE_RESET)
        else $error("routing register not cleared by reset");

    a_db0_field0_dest: assert property (@(posedge aclk) disable iff (!aresetn)
        (db0_pending[0] && route_reg[0][3:0] <= ICR_CODE_DEST7)
            |-> irq_out[route_reg[0][2:0]])
        else $error("doorbell 0 bit 0 not at its destination");

    a_disable_code: assert property (@(posedge aclk) disable iff (!aresetn)
        (db1_pending == 16'h0001 && route_reg[2][3:0] == ICR_CODE_DISABLE)
            |-> dest_grp[1] == '0)
        else $error("disabled condition drove an output");

    a_rxq_high_field: assert property (@(posedge aclk) disable iff (!aresetn)
        (rxq_pending[12] && route_reg[9][19:16] <= ICR_CODE_DEST7)
            |-> dest_grp[4][route_reg[9][18:16]])
        else $error("receive queue 12 misrouted");

    a_txq_field: assert property (@(posedge aclk) disable iff (!aresetn)
        (txq_pending[15] && route_reg[11][31:28] <= ICR_CODE_DEST7)
            |-> dest_grp[5][route_reg[11][30:28]])
        else $error("transmit queue 15 misrouted");

    a_no_pending_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        (db0_pending == '0 && db1_pending == '0 && db2_pending == '0 && db3_pending == '0
            && rxq_pending == '0 && txq_pending == '0) |-> irq_out == '0)
        else $error("output raised with nothing pending");

    a_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && wr_hit[7] && w_strb == 4'hf) |=> route_reg[7] == $past(w_data))
        else $error("full write did not store");

    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wr_done |-> s_axi_bresp == ($past(|wr_hit) ? ICR_RESP_OKAY : ICR_RESP_SLVERR))
        else $error("write response code wrong");

    a_dest_code: assert property (@(posedge aclk) disable iff (!aresetn)
        (db2_pending == 16'h0040 && db0_pending == '0 && db1_pending == '0
            && db3_pending == '0 && rxq_pending == '0 && txq_pending == '0
            && route_reg[4][27:24] == 4'h2) |-> irq_out == 8'h04)
        else $error("code 0010b did not select destination 2 alone");

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake checks

    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence

    sequence s_w_taken;
        s_axi_wvalid && s_axi_wready;
    endsequence

    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // Both halves taken at one edge: wr_go spends one edge, then the response rises
    sequence s_wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_aw_taken ##0 s_w_taken |=> s_wr_answer)
        else $error("write response late or early");

    // Reads answer on the very next edge
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ar_taken |=> s_axi_rvalid)
        else $error("read data not one edge after its address");

    // A response is taken once; a new one needs a fresh request
    a_bresp_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
        else $error("write response repeated");

    a_rresp_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
        else $error("read data repeated");

    // A second request waits until the pending response has been taken
    a_write_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while a response is pending");

    a_read_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while read data is pending");

    // Both holding flags free up on the edge that performs the write
    a_holds_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> !aw_held && !w_held)
        else $error("write halves still held after the write");

    a_bus_reset: assert property (@(posedge aclk)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !aw_held && !w_held)
        else $error("bus state not cleared by reset");

    // Unmapped reads return zero so software never sees stale data
    a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && !(|rd_hit))
            |=> s_axi_rdata == '0 && s_axi_rresp == ICR_RESP_SLVERR)
        else $error("unmapped read not answered with zero and an error");

    ////////////////////////////////////////////////////////////////////////////
    // Per-register checks

    for (genvar r = 0; r < ICR_NUM_REGS; r++) begin : g_reg_chk
        a_reg_reset: assert property (@(posedge aclk)
            !aresetn |=> route_reg[r] == ICR_ROUTE_RESET)
            else $error("routing register not cleared by reset");

        // Read data is the register as it stood at the edge that took the address
        a_reg_read: assert property (@(posedge aclk) disable iff (!aresetn)
            (s_axi_arvalid && s_axi_arready && rd_hit[r])
                |=> s_axi_rdata == $past(route_reg[r]) && s_axi_rresp == ICR_RESP_OKAY)
            else $error("read data differs from its routing register");

        // Lane 0 holds the two lowest fields; a write without its strobe keeps them
        a_lane_kept: assert property (@(posedge aclk) disable iff (!aresetn)
            (wr_go && wr_hit[r] && !w_strb[0]) |=> $stable(route_reg[r][7:0]))
            else $error("byte lane changed without its strobe");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-condition routing checks

    for (genvar g = 0; g < ICR_NUM_GROUPS; g++) begin : g_grp_chk
        // Each group's lines must reach the merged outputs untouched
        a_grp_merged: assert property (@(posedge aclk) disable iff (!aresetn)
            (irq_out & dest_grp[g]) == dest_grp[g])
            else $error("group destination missing from the outputs");

        for (genvar n = 0; n < ICR_NUM_COND; n++) begin : g_cond_chk
            // Field of condition n: register FLD_REG, bits FLD_LSB upward
            localparam int FLD_REG = 2 * g + n / ICR_FIELDS_REG;
            localparam int FLD_LSB = ICR_FIELD_W * (n % ICR_FIELDS_REG);

            a_cond_route: assert property (@(posedge aclk) disable iff (!aresetn)
                (pend_grp[g][n]
                    && route_reg[FLD_REG][FLD_LSB +: ICR_FIELD_W] <= ICR_CODE_DEST7)
                    |-> dest_grp[g][route_reg[FLD_REG][FLD_LSB +: 3]])
                else $error("pending condition absent from its destination");

            // Reserved codes drive nothing, the same as the disable code
            a_cond_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
                (pend_grp[g] == (ICR_NUM_COND'(1) << n)
                    && route_reg[FLD_REG][FLD_LSB +: ICR_FIELD_W] > ICR_CODE_DEST7)
                    |-> dest_grp[g] == '0)
                else $error("disabled condition drove an output");

            a_cond_alone: assert property (@(posedge aclk) disable iff (!aresetn)
                (pend_grp[g] == (ICR_NUM_COND'(1) << n)
                    && route_reg[FLD_REG][FLD_LSB +: ICR_FIELD_W] <= ICR_CODE_DEST7)
                    |-> $onehot(dest_grp[g]))
                else $error("lone condition reached more than one output");
        end
    end

endmodule // icr_router

//--- verification/icr_core_model.sv
// Model of the cores' interrupt inputs: remembers every destination line seen high.
// Assumes level lines from the router, sampled on the router's own clock.
`timescale 1ns/1ps
module icr_core_model
    import icr_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [ICR_NUM_DEST-1:0] irq_in,
    output logic      [ICR_NUM_DEST-1:0] seen
);
    // Sticky, so a level that drops before software looks is still counted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen <= '0;
        end else begin
            seen <= seen | irq_in;
        end
    end
endmodule // icr_core_model

//--- verification/icr_router_test.sv
// Self-checking bench: routing registers over AXI4-Lite, routing codes, reset, unmapped access.
// Assumes the router answers on its own handshakes; every wait is cut by the watchdog.
`timescale 1ns/1ps
module icr_router_test
    import icr_pkg::*;
;
    typedef struct packed {
        logic [2:0] g;
        logic [3:0] b;
        logic [3:0] code;
        logic [7:0] exp;
    } icr_row_t;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr, a;
    logic [31:0] wdata, rdata, d, dd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  irq, seen;
    logic [15:0] pend [6];
    int          n_errors, num_checks;
    icr_row_t    rows [11] = '{
        '{3'd0, 4'd6, 4'h2, 8'h04}, '{3'd1, 4'd9, 4'h1, 8'h02}, '{3'd2, 4'd6, 4'h2, 8'h04},
        '{3'd3, 4'd15, 4'h7, 8'h80}, '{3'd4, 4'd6, 4'h2, 8'h04}, '{3'd5, 4'd6, 4'h3, 8'h08},
        '{3'd0, 4'd0, 4'h4, 8'h10}, '{3'd4, 4'd12, 4'h5, 8'h20}, '{3'd5, 4'd3, 4'h6, 8'h40},
        '{3'd1, 4'd0, 4'hf, 8'h00}, '{3'd2, 4'd8, 4'h0, 8'h01}};

    icr_router dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .db0_pending(pend[0]), .db1_pending(pend[1]),
        .db2_pending(pend[2]), .db3_pending(pend[3]), .rxq_pending(pend[4]),
        .txq_pending(pend[5]), .irq_out(irq));
    icr_core_model core (.aclk(aclk), .aresetn(aresetn), .irq_in(irq), .seen(seen));

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Ready is looked at mid-cycle, so the drop after its edge never races the design
    task automatic wr(input logic [11:0] wa, input logic [31:0] wd);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        awaddr  <= wa;
        wdata   <= wd;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t  = wvalid && wready;
            b_t  = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end while (!b_t);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] ra, output logic [31:0] rd_data);
        logic ar_t, r_t;
        @(posedge aclk);
        araddr  <= ra;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge aclk);
            ar_t    = arvalid && arready;
            r_t     = rvalid;
            rd_data = rdata;
            resp    = rresp;
            @(posedge aclk);
            if (ar_t) arvalid <= 1'b0;
        end while (!r_t);
        rready <= 1'b0;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    initial begin
        #(3000 * 100);
        n_errors++;
        complete_run();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        foreach (pend[i]) pend[i] = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < ICR_NUM_REGS; i++) begin
            rd(ICR_REG_ADDRS[i*12 +: 12], d);
            chk("reset value", ICR_ROUTE_RESET, d);
        end
        @(posedge aclk);
        pend[5] <= 16'h8000;
        @(negedge aclk);
        chk("irq after reset", 8'h01, irq);
        $display("reset test done");
        foreach (rows[i]) begin
            a  = ICR_REG_ADDRS[(2 * rows[i].g + rows[i].b[3]) * 12 +: 12];
            dd = 32'(rows[i].code) << (4 * rows[i].b[2:0]);
            @(posedge aclk);
            pend[5] <= '0;
            wr(a, dd);
            chk("write resp", ICR_RESP_OKAY, resp);
            rd(a, d);
            chk("read back", dd, d);
            @(posedge aclk);
            pend[rows[i].g] <= 16'h0001 << rows[i].b;
            @(negedge aclk);
            chk("irq row", rows[i].exp, irq);
            @(posedge aclk);
            pend[rows[i].g] <= '0;
        end
        $display("routing table test done");
        // Mid-run reset must undo programming done by the table
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ICR_DB1_LOW, d);
        chk("route after reset", ICR_ROUTE_RESET, d);
        wr(ICR_DB1_LOW, 32'h0000_0353);
        wr(ICR_TXQ_HIGH, 32'h0000_0008);
        @(posedge aclk);
        pend[1] <= 16'h0007;
        @(negedge aclk);
        chk("irq merged", 8'h28, irq);
        @(posedge aclk);
        pend[1] <= '0;
        pend[5] <= 16'h0100;
        @(negedge aclk);
        chk("irq reserved code", 8'h00, irq);
        @(posedge aclk);
        pend[5] <= '0;
        @(negedge aclk);
        chk("core lines seen", 8'h28, seen);
        wr(12'h300, 32'hffff_ffff);
        chk("unmapped write resp", ICR_RESP_SLVERR, resp);
        rd(12'h300, d);
        chk("unmapped read data", 32'h0, d);
        chk("unmapped read resp", ICR_RESP_SLVERR, resp);
        wstrb <= 4'h2;
        wr(ICR_DB0_HIGH, 32'hffff_ffff);
        rd(ICR_DB0_HIGH, d);
        chk("lane write", 32'h0000_ff00, d);
        $display("reset, merge and unmapped tests done");
        complete_run();
    end
endmodule // icr_router_test
